// ### design/csel_pkg.sv
// Package with encodings, reset values and setting codes for the selector
// How it works
// - Start setting 0 communication, 1 terminals
// - Speed setting 0 comm, 1 external, 2 comm-only
// - Network setting 0: option only source
// - Network setting 2: PU connector RS-485 source
// - Network 9999: PU connector, option overrides
// - Local setting 2 PU, 3 USB, 4 panel
// - Local 9999: USB, then unit, then panel
// - Reads always; writes/starts only from source
// - Auto network plus option: reject RS-485 commands
// - Local auto: RS-485 never becomes local source
// - Both PU connector, no option fitted: local wins, no network
// - Setting changes apply only after reset
// - Modbus only in network mode, any network setting
// - Panel mode lamps off unless panel source
// - Option source without option: no network
// - Settings writable if group zero or option
// - Source settings writable while motor stopped
package csel_pkg;

  // ****************************************************************
  // Setting codes
  // ****************************************************************
  localparam logic [13:0] CSEL_SET_0    = 14'h0000; // Code 0
  localparam logic [13:0] CSEL_SET_1    = 14'h0001; // Code 1
  localparam logic [13:0] CSEL_SET_2    = 14'h0002; // Code 2
  localparam logic [13:0] CSEL_SET_3    = 14'h0003; // Code 3
  localparam logic [13:0] CSEL_SET_4    = 14'h0004; // Code 4
  localparam logic [13:0] CSEL_SET_AUTO = 14'h270F; // Code 9999

  // Reset values of the stored settings
  localparam logic [13:0] CSEL_START_RST = 14'h0000;
  localparam logic [13:0] CSEL_SPEED_RST = 14'h0000;
  localparam logic [13:0] CSEL_NET_RST   = 14'h270F;
  localparam logic [13:0] CSEL_LOCAL_RST = 14'h270F;

  // Cycles after reset release before the selection is latched
  localparam logic [1:0]  CSEL_LATCH_CYC = 2'h2;

  // ****************************************************************
  // Interfaces, one-hot bit positions
  // ****************************************************************
  localparam int CSEL_IF_PANEL = 0; // Operation panel
  localparam int CSEL_IF_USB   = 1; // USB connector
  localparam int CSEL_IF_UNIT  = 2; // Parameter unit on PU connector
  localparam int CSEL_IF_RS485 = 3; // RS-485 on PU connector
  localparam int CSEL_IF_OPT   = 4; // Communication option
  localparam int CSEL_IF_N     = 5;

  typedef logic [CSEL_IF_N-1:0] csel_if_t;

  // Operation modes
  typedef enum logic [1:0] {
    CSEL_MODE_EXT,
    CSEL_MODE_LOCAL,
    CSEL_MODE_NET,
    CSEL_MODE_COMB
  } csel_mode_e;

endpackage : csel_pkg

// ### design/csel_sync.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module csel_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_reg; // First stage, read only by second stage

  // Two stages
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end
endmodule : csel_sync

// ### design/csel_store.sv
// Holds the four source settings and the write gating
`timescale 1ns/1ps
module csel_store
  import csel_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        wr_en,
  input  wire logic [1:0]  wr_sel,
  input  wire logic [13:0] wr_data,
  input  wire logic        write_ok,
  output logic      [13:0] start_reg,
  output logic      [13:0] speed_reg,
  output logic      [13:0] net_reg,
  output logic      [13:0] local_reg
);
  // Setting store, written when allowed
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      start_reg <= CSEL_START_RST;
      speed_reg <= CSEL_SPEED_RST;
      net_reg   <= CSEL_NET_RST;
      local_reg <= CSEL_LOCAL_RST;
    end else if (wr_en && write_ok) begin
      case (wr_sel)
        2'h0:    start_reg <= wr_data;
        2'h1:    speed_reg <= wr_data;
        2'h2:    net_reg   <= wr_data;
        default: local_reg <= wr_data;
      endcase
    end
  end
endmodule : csel_store

// ### design/csel_top.sv
// Command source selector: latches and applies source settings
`timescale 1ns/1ps
module csel_top
  import csel_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rstn,
  // Setting write port
  input  wire logic                 set_wr,
  input  wire logic [1:0]           set_sel,
  input  wire logic [13:0]          set_data,
  input  wire logic                 user_group_zero,
  input  wire logic                 motor_stopped,
  output logic                      set_wr_ok,
  // Pins from the outside world
  input  wire logic                 option_present,
  input  wire logic                 usb_present,
  input  wire logic                 unit_present,
  // Operation mode and requests
  input  wire csel_pkg::csel_mode_e op_mode,
  input  wire logic                 net_req,
  input  wire logic                 modbus_active,
  input  wire csel_pkg::csel_if_t   wr_req,
  input  wire csel_pkg::csel_if_t   start_req,
  input  wire csel_pkg::csel_if_t   freq_req,
  input  wire csel_pkg::csel_if_t   read_req,
  // Decisions
  output csel_pkg::csel_if_t        wr_grant,
  output csel_pkg::csel_if_t        start_grant,
  output csel_pkg::csel_if_t        freq_grant,
  output csel_pkg::csel_if_t        read_grant,
  output logic                      start_from_terms,
  output logic                      freq_from_terms,
  output logic                      analog_freq_en,
  output logic                      net_switch_ok,
  output logic                      mode_lamps_en,
  output logic                      sel_valid,
  output csel_pkg::csel_if_t        local_src,
  output csel_pkg::csel_if_t        net_src
);
  import csel_pkg::*;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [2:0] pins_s; // Synced option, usb, unit

  csel_sync #(.W(3)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .din   ({option_present, usb_present, unit_present}),
    .dout  (pins_s)
  );

  logic opt_s;  // Option fitted
  logic usb_s;  // USB attached
  logic unit_s; // Parameter unit attached
  assign opt_s  = pins_s[2];
  assign usb_s  = pins_s[1];
  assign unit_s = pins_s[0];

  // ****************************************************************
  // Settings store
  // ****************************************************************
  logic [13:0] start_source_setting;   // Start source
  logic [13:0] speed_source_setting;   // Speed source
  logic [13:0] network_source_setting; // Network source
  logic [13:0] local_source_setting;   // Local panel source

  // Writes gated by group read setting or option, and motor stop
  assign set_wr_ok = (user_group_zero || opt_s)
                     && motor_stopped;

  csel_store u_store (
    .clock     (clock),
    .rstn      (rstn),
    .wr_en     (set_wr),
    .wr_sel    (set_sel),
    .wr_data   (set_data),
    .write_ok  (set_wr_ok),
    .start_reg (start_source_setting),
    .speed_reg (speed_source_setting),
    .net_reg   (network_source_setting),
    .local_reg (local_source_setting)
  );

  // ****************************************************************
  // Selection functions
  // ****************************************************************
  // Network mode source from setting and option presence
  function automatic csel_if_t net_pick(input logic [13:0] s,
                                        input logic        opt);
    csel_if_t r;
    r = '0;
    if (s == CSEL_SET_0) begin
      r[CSEL_IF_OPT] = 1'b1;
    end else if (s == CSEL_SET_2) begin
      r[CSEL_IF_RS485] = 1'b1;
    end else if (opt) begin
      r[CSEL_IF_OPT] = 1'b1;
    end else begin
      r[CSEL_IF_RS485] = 1'b1;
    end
    return r;
  endfunction : net_pick

  // Local mode source; RS-485 is never chosen automatically
  function automatic csel_if_t local_pick(input logic [13:0] s,
                                          input logic        usb,
                                          input logic        unit);
    csel_if_t r;
    r = '0;
    case (s)
      CSEL_SET_2: begin
        r[CSEL_IF_UNIT]  = 1'b1;
        r[CSEL_IF_RS485] = 1'b1;
      end
      CSEL_SET_3: r[CSEL_IF_USB]   = 1'b1;
      CSEL_SET_4: r[CSEL_IF_PANEL] = 1'b1;
      default: begin
        if (usb) begin
          r[CSEL_IF_USB] = 1'b1;
        end else if (unit) begin
          r[CSEL_IF_UNIT] = 1'b1;
        end else begin
          r[CSEL_IF_PANEL] = 1'b1;
        end
      end
    endcase
    return r;
  endfunction : local_pick

  // ****************************************************************
  // Latch after reset release
  // ****************************************************************
  logic [1:0] wait_reg; // Lets settings and pins settle
  logic       latched_reg;

  // Count a few cycles after reset release, then latch once
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= '0;
    end else if (wait_reg != CSEL_LATCH_CYC) begin
      wait_reg <= wait_reg + 2'h1;
    end
  end

  logic     start_ext_reg; // Start from terminals
  logic     freq_ext_reg;  // Speed setting external or comm-only
  logic     analog_reg;    // Analog terminal honoured
  logic     net_ok_reg;    // Network mode allowed
  csel_if_t local_reg;     // Local mode source
  csel_if_t net_reg;       // Network mode source
  // Option presence as seen at the capture edge; later pin changes are
  // ignored, so checks on the network gate must use this copy
  logic     opt_seen_reg;

  // Capture the selection once; held until next reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      latched_reg   <= 1'b0;
      start_ext_reg <= 1'b0;
      freq_ext_reg  <= 1'b0;
      analog_reg    <= 1'b0;
      net_ok_reg    <= 1'b0;
      local_reg     <= '0;
      net_reg       <= '0;
      opt_seen_reg  <= 1'b0;
    end else if (!latched_reg && wait_reg == CSEL_LATCH_CYC) begin
      latched_reg   <= 1'b1;
      start_ext_reg <= (start_source_setting == CSEL_SET_1);
      freq_ext_reg  <= (speed_source_setting != CSEL_SET_0);
      analog_reg    <= (speed_source_setting == CSEL_SET_1);
      local_reg     <= local_pick(local_source_setting, usb_s, unit_s);
      net_reg       <= net_pick(network_source_setting, opt_s);
      opt_seen_reg  <= opt_s;
      // Option source needs option; both on PU connector without option blocks net
      net_ok_reg    <=
        !(net_pick(network_source_setting, opt_s) == csel_if_t'(5'h10)
          && !opt_s)
        && !(network_source_setting == CSEL_SET_2
             && local_source_setting == CSEL_SET_2 && !opt_s);
    end
  end

  // ****************************************************************
  // Request gating
  // ****************************************************************
  csel_if_t active; // Source of the current mode
  logic     gate_on;

  // Active source follows the operation mode
  always_comb begin
    active = '0;
    case (op_mode)
      CSEL_MODE_LOCAL: active = local_reg;
      CSEL_MODE_NET:   active = net_ok_reg ? net_reg : '0;
      CSEL_MODE_COMB:  active = local_reg;
      default:         active = '0;
    endcase
  end

  // Modbus only served in network mode, for any network source
  assign gate_on = latched_reg
                   && !(modbus_active && op_mode != CSEL_MODE_NET);

  // Writes, starts and frequency only from the selected source
  assign wr_grant    = gate_on ? (wr_req & active) : '0;
  assign start_grant = (gate_on && !start_ext_reg)
                       ? (start_req & active) : '0;
  assign freq_grant  = (gate_on && !(freq_ext_reg && analog_reg))
                       ? (freq_req & active) : '0;
  assign read_grant  = read_req;

  assign start_from_terms = start_ext_reg;
  assign freq_from_terms  = freq_ext_reg && analog_reg;
  assign analog_freq_en   = !freq_ext_reg || analog_reg;
  assign net_switch_ok    = net_ok_reg && net_req;
  assign mode_lamps_en    = local_reg[CSEL_IF_PANEL]
                            && op_mode != CSEL_MODE_NET;
  assign sel_valid        = latched_reg;
  assign local_src        = local_reg;
  assign net_src          = net_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  held_sel_a: assert property (@(posedge clock) disable iff (!rstn)
    $past(latched_reg) |-> $stable(local_reg) && $stable(net_reg))
    else $error("selection changed after latch");

  latch_time_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(wait_reg == CSEL_LATCH_CYC) |=> latched_reg)
    else $error("selection not latched in time");

  read_pass_a: assert property (@(posedge clock) disable iff (!rstn)
    read_grant == read_req)
    else $error("read refused");

  grant_src_a: assert property (@(posedge clock) disable iff (!rstn)
    (wr_grant & ~active) == '0)
    else $error("write granted to wrong source");

  rs485_rej_a: assert property (@(posedge clock) disable iff (!rstn)
    (net_reg[CSEL_IF_OPT] && op_mode == CSEL_MODE_NET)
    |-> !wr_grant[CSEL_IF_RS485] && !start_grant[CSEL_IF_RS485])
    else $error("RS-485 command taken with option source");

  lamp_off_a: assert property (@(posedge clock) disable iff (!rstn)
    !local_reg[CSEL_IF_PANEL] |-> !mode_lamps_en)
    else $error("lamps lit without panel source");

  opt_net_a: assert property (@(posedge clock) disable iff (!rstn)
    (latched_reg && net_reg[CSEL_IF_OPT] && !opt_seen_reg)
    |-> !net_switch_ok)
    else $error("network allowed without option");

  start_ext_a: assert property (@(posedge clock) disable iff (!rstn)
    start_ext_reg |-> start_grant == '0)
    else $error("comm start while terminals selected");

  modbus_a: assert property (@(posedge clock) disable iff (!rstn)
    (modbus_active && op_mode != CSEL_MODE_NET) |-> wr_grant == '0)
    else $error("Modbus served outside network mode");

  set_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    set_wr_ok |-> motor_stopped)
    else $error("setting write while running");

  // No write, start or frequency is granted until the selection has been captured
  early_grant_a: assert property (@(posedge clock) disable iff (!rstn)
    !latched_reg |-> (wr_grant | start_grant | freq_grant) == '0)
    else $error("grant before selection latched");

  // Network mode always has exactly one source once captured
  net_onehot_a: assert property (@(posedge clock) disable iff (!rstn)
    latched_reg |-> $onehot(net_reg))
    else $error("network source not a single interface");

  // Frequency over RS-485 is refused while the option is the source
  rs485_freq_a: assert property (@(posedge clock) disable iff (!rstn)
    (net_reg[CSEL_IF_OPT] && op_mode == CSEL_MODE_NET)
    |-> !freq_grant[CSEL_IF_RS485])
    else $error("RS-485 frequency taken with option source");

  // RS-485 only rides along with the unit on an explicit setting
  local_rs485_a: assert property (@(posedge clock) disable iff (!rstn)
    local_reg[CSEL_IF_RS485] |-> local_reg[CSEL_IF_UNIT])
    else $error("RS-485 chosen alone as local source");

  // External speed source blocks every communication frequency
  speed_ext_a: assert property (@(posedge clock) disable iff (!rstn)
    (freq_ext_reg && analog_reg) |-> freq_grant == '0)
    else $error("comm frequency while terminals selected");

  // A blocked network mode grants no command at all
  net_block_a: assert property (@(posedge clock) disable iff (!rstn)
    (latched_reg && !net_ok_reg && op_mode == CSEL_MODE_NET)
    |-> (wr_grant | start_grant | freq_grant) == '0)
    else $error("command taken with network mode blocked");

  // Setting writes need the group setting at zero or an option
  group_gate_a: assert property (@(posedge clock) disable iff (!rstn)
    set_wr_ok |-> (user_group_zero || opt_s))
    else $error("setting write without group or option");

endmodule : csel_top

// ### test/csel_host_model.sv
// Far-side hosts, keypads and option raising requests on five interfaces
`timescale 1ns/1ps
module csel_host_model
  import csel_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          run,
  input  wire logic          mb_ok,
  input  wire logic          mb_rogue,
  output csel_pkg::csel_if_t wr_req,
  output csel_pkg::csel_if_t start_req,
  output csel_pkg::csel_if_t freq_req,
  output csel_pkg::csel_if_t read_req,
  output logic               modbus_active
);
  // ****************************************************************
  // Request generator
  // ****************************************************************
  // Requests move just after the falling edge and hold a whole cycle
  always @(negedge clock) begin
    #1;
    if (run) begin
      wr_req    <= csel_if_t'($urandom);
      start_req <= csel_if_t'($urandom);
      freq_req  <= csel_if_t'($urandom);
      read_req  <= csel_if_t'($urandom);
      // Modbus framing only in network mode at code 2, unless told
      modbus_active <= 1'($urandom) & (mb_ok | mb_rogue);
    end else begin
      // Idle hosts raise nothing
      {wr_req, start_req, freq_req, read_req} <= '0;
      modbus_active <= 1'b0;
    end
  end
endmodule : csel_host_model

// ### test/csel_top_tb.sv
// Self-checking bench for the command source selector
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end
module csel_top_tb;
  import csel_pkg::*;
  // ****************************************************************
  // Signals and model state
  // ****************************************************************
  logic       clock, rstn, set_wr, user_group_zero, motor_stopped;
  logic [1:0] set_sel;
  logic [13:0] set_data;
  logic       option_present, usb_present, unit_present, net_req;
  logic       run, mb_ok, mb_rogue, modbus_active, set_wr_ok, sel_valid;
  logic       start_from_terms, freq_from_terms, analog_freq_en;
  logic       net_switch_ok, mode_lamps_en;
  csel_mode_e op_mode;
  csel_if_t   wr_req, start_req, freq_req, read_req, local_src, net_src;
  csel_if_t   wr_grant, start_grant, freq_grant, read_grant;
  int         err_total, n_checks, lsrc, nsrc, s[4];
  logic       opt, usb, unit, netok;
  int         nets[3] = '{0, 2, 9999};
  int         locs[4] = '{2, 3, 4, 9999};

  csel_top u_csel_top (.clock(clock), .rstn(rstn), .set_wr(set_wr),
    .set_sel(set_sel), .set_data(set_data),
    .user_group_zero(user_group_zero), .motor_stopped(motor_stopped),
    .set_wr_ok(set_wr_ok), .option_present(option_present),
    .usb_present(usb_present), .unit_present(unit_present),
    .op_mode(op_mode), .net_req(net_req), .modbus_active(modbus_active),
    .wr_req(wr_req), .start_req(start_req), .freq_req(freq_req),
    .read_req(read_req), .wr_grant(wr_grant), .start_grant(start_grant),
    .freq_grant(freq_grant), .read_grant(read_grant),
    .start_from_terms(start_from_terms), .freq_from_terms(freq_from_terms),
    .analog_freq_en(analog_freq_en), .net_switch_ok(net_switch_ok),
    .mode_lamps_en(mode_lamps_en), .sel_valid(sel_valid),
    .local_src(local_src), .net_src(net_src));

  csel_host_model u_csel_host_model (.clock(clock), .run(run),
    .mb_ok(mb_ok), .mb_rogue(mb_rogue), .wr_req(wr_req),
    .start_req(start_req), .freq_req(freq_req), .read_req(read_req),
    .modbus_active(modbus_active));

  // ****************************************************************
  // Clock, verdict and watchdog
  // ****************************************************************
  // 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Prints counts and the verdict, then ends the run
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  // Cuts a hang short well beyond the expected run length
  initial begin
    #(25ns * 8000);
    err_total++;
    print_verdict();
  end

  // ****************************************************************
  // Reset, setting writes in the latch window and latch checks
  // ****************************************************************
  task automatic do_cfg(input logic [1:0] sa, input int va,
                        input logic [1:0] sb, input int vb, input int hold);
    @(negedge clock);
    {rstn, run, set_wr} = 3'b000;
    {option_present, usb_present, unit_present} = {opt, usb, unit};
    {user_group_zero, motor_stopped} = 2'b11;
    repeat (hold) @(negedge clock);
    // Two writes land before the selection is captured
    rstn = 1'b1; set_wr = 1'b1; set_sel = sa; set_data = 14'(va);
    @(negedge clock);
    set_sel = sb; set_data = 14'(vb);
    @(negedge clock);
    set_wr = 1'b0;
    repeat (4) @(negedge clock);
    s = '{0, 0, 9999, 9999};
    s[sa] = va;
    s[sb] = vb;
    // Model of the local and network sources
    case (s[3])
      2: lsrc = (1 << CSEL_IF_UNIT) | (1 << CSEL_IF_RS485);
      3: lsrc = 1 << CSEL_IF_USB;
      4: lsrc = 1 << CSEL_IF_PANEL;
      default: lsrc = usb ? 1 << CSEL_IF_USB :
                      unit ? 1 << CSEL_IF_UNIT : 1 << CSEL_IF_PANEL;
    endcase
    nsrc = (s[2] == 0 || (s[2] == 9999 && opt)) ? 1 << CSEL_IF_OPT
                                                : 1 << CSEL_IF_RS485;
    netok = !(nsrc[CSEL_IF_OPT] && !opt) && !(s[2] == 2 && s[3] == 2 && !opt);
    `CHK(sel_valid, 1'b1)
    `CHK(local_src, csel_if_t'(lsrc))
    `CHK(net_src, csel_if_t'(nsrc))
    // Late write and pin changes must not move the selection
    set_wr = 1'b1; set_sel = 2'h3; set_data = 14'h0003;
    {option_present, usb_present, unit_present} = ~{opt, usb, unit};
    @(negedge clock);
    set_wr = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(local_src, csel_if_t'(lsrc))
    `CHK(net_src, csel_if_t'(nsrc))
    {option_present, usb_present, unit_present} = {opt, usb, unit};
    repeat (3) @(negedge clock);
    run = 1'b1;
  endtask : do_cfg

  // ****************************************************************
  // Random traffic with a per-cycle model compare
  // ****************************************************************
  task automatic traffic(input int n);
    int  act;
    int  gs;
    int  gf;
    logic mbb;
    repeat (n) begin
      @(negedge clock);
      act = (op_mode == CSEL_MODE_LOCAL || op_mode == CSEL_MODE_COMB) ? lsrc
          : (op_mode == CSEL_MODE_NET && netok) ? nsrc : 0;
      mbb = modbus_active && op_mode != CSEL_MODE_NET;
      `CHK(wr_grant, csel_if_t'(mbb ? 0 : wr_req & act))
      // Start and frequency expectations from the captured settings
      gs = (mbb || s[0] == 1) ? 0 : start_req & act;
      gf = (mbb || s[1] == 1) ? 0 : freq_req & act;
      `CHK(start_grant, csel_if_t'(gs))
      `CHK(freq_grant, csel_if_t'(gf))
      `CHK(read_grant, read_req)
      `CHK(set_wr_ok, (user_group_zero | opt) & motor_stopped)
      `CHK(mode_lamps_en, 1'(lsrc[0] && op_mode != CSEL_MODE_NET))
      if (net_req) `CHK(net_switch_ok, netok)
      if (op_mode == CSEL_MODE_NET) begin
        `CHK(start_from_terms, 1'(s[0] == 1))
        `CHK(freq_from_terms, 1'(s[1] == 1))
        if (s[1] != 0) `CHK(analog_freq_en, 1'(s[1] == 1))
      end
      op_mode = csel_mode_e'($urandom_range(3, 0));
      {net_req, mb_rogue, user_group_zero, motor_stopped} = 4'($urandom);
      mb_ok = op_mode == CSEL_MODE_NET && s[2] == 2;
    end
  endtask : traffic

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(32'hA7CB));
    {rstn, set_wr, run, mb_ok, mb_rogue, net_req} = '0;
    {set_sel, set_data, opt, usb, unit} = '0;
    {option_present, usb_present, unit_present} = '0;
    {user_group_zero, motor_stopped} = 2'b11;
    op_mode = CSEL_MODE_EXT;
    {err_total, n_checks} = '0;
    // Every network and local code, with and without an option
    for (int i = 0; i < 24; i++) begin
      {usb, unit} = 2'($urandom);
      opt = i[0];
      do_cfg(2'h2, nets[i / 8], 2'h3, locs[(i / 2) % 4], i == 0 ? 12 : 2);
      traffic(25);
    end
    // Every start and speed code
    for (int k = 0; k < 6; k++) begin
      {opt, usb, unit} = 3'($urandom);
      do_cfg(2'h0, k % 2, 2'h1, k / 2, 2);
      traffic(25);
    end
    print_verdict();
  end
endmodule : csel_top_tb
